// ==== hdl/pmp_mgmt_port.sv ====
// management port, mode pins and axi4-lite window of the serial pcs core
// Operation
// R1 - host gives 6-bit offset; offsets decode upward from zero
// R2 - read-valid pulses while 16-bit read data holds the addressed register
// R3 - ready output is constantly one
// R4 - serial mode: side pin 0 makes mac-side, 1 phy-side negotiation
// R5 - pcs pin 0 selects serial pcs, 1 selects 1000base-x pcs
// R6 - serial pcs rate code 10 = 1g, 01 = 100m, 00 = 10m
// R7 - 1000base-x mode forces 1g rate, rate pins ignored
// R8 - short-timer pin makes the negotiation link timer run much faster
// R9 - integrator loops transmit clock-enable output to its input
// R10 - integrator loops receive clock-enable output to its input
// R11 - direction high requests write, low requests read
// R12 - request is one cycle with offset, direction, data valid together
// R13 - write lands in request cycle; read-valid follows a fixed delay
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "pmp_regs.svh"
module pmp_mgmt_port
    import pmp_pkg::*;
#(
    parameter int LINK_CYC = `PMP_LINK_CYC, // normal link timer count
    parameter int RD_LAT = `PMP_RD_LAT // read latency, at least 2
) (
    input wire logic core_clk_i, // 10 mhz clock
    input wire logic resetn_i, // async reset, low
    input wire logic mgmt_request_i, // transaction request
    input wire logic mgmt_wr_rdn_i, // 1 write, 0 read
    input wire logic [5:0] mgmt_offset_i, // register offset
    input wire logic [15:0] mgmt_wdata_i, // write data
    output logic [15:0] mgmt_rdata_o, // read data
    output logic mgmt_rdata_valid_o, // read complete pulse
    output logic mgmt_ready_o, // always ready
    input wire logic side_phy_i, // 0 mac side, 1 phy side (pin)
    input wire logic pcs_gbe_i, // 0 serial pcs, 1 1000base-x (pin)
    input wire logic [1:0] rate_sel_i, // rate code (pin)
    input wire logic timer_short_i, // short link timer (pin)
    output logic an_phy_side_o, // negotiation acts phy side
    output logic [1:0] pcs_sel_o, // one-hot pcs variant
    output logic [2:0] speed_o, // one-hot adaptation rate
    output logic link_timer_done_o, // link timer expiry pulse
    input wire logic tx_ce_sink_i, // looped transmit enable
    output logic tx_ce_source_o, // transmit enable source
    input wire logic rx_ce_sink_i, // looped receive enable
    output logic rx_ce_source_o, // receive enable source
    output logic [1:0] ce_seen_o, // loopback enables seen {rx,tx}
    input wire logic [7:0] s_axi_awaddr, // axi write address
    input wire logic s_axi_awvalid, // axi
    output logic s_axi_awready, // axi
    input wire logic [31:0] s_axi_wdata, // axi
    input wire logic [3:0] s_axi_wstrb, // axi
    input wire logic s_axi_wvalid, // axi
    output logic s_axi_wready, // axi
    output logic [1:0] s_axi_bresp, // axi
    output logic s_axi_bvalid, // axi
    input wire logic s_axi_bready, // axi
    input wire logic [7:0] s_axi_araddr, // axi read address
    input wire logic s_axi_arvalid, // axi
    output logic s_axi_arready, // axi
    output logic [31:0] s_axi_rdata, // axi
    output logic [1:0] s_axi_rresp, // axi
    output logic s_axi_rvalid, // axi
    input wire logic s_axi_rready // axi
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change accepted when stages two and three agree
    logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_d;
    logic side_s, gbe_s, short_s;
    logic [1:0] rate_s;
    always_comb begin
        pin_d = pin_q;
        if (pin_s2_q == pin_s3_q) begin
            pin_d = pin_s3_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
            pin_q <= 5'h00;
        end else begin
            pin_s1_q <= {timer_short_i, rate_sel_i, pcs_gbe_i, side_phy_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
        end
    end
    assign side_s = pin_q[`PMP_MODE_SIDE_BIT];
    assign gbe_s = pin_q[`PMP_MODE_GBE_BIT];
    assign rate_s = pin_q[`PMP_MODE_RATE_LSB +: 2];
    assign short_s = pin_q[`PMP_MODE_SHORT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    function automatic pmp_speed_type rate_decode(input logic gbe, input logic [1:0] code);
        if (gbe) begin
            return PMP_SPD_1G; // R7
        end
        unique case (code) // R6
            `PMP_RATE_1G: return PMP_SPD_1G;
            `PMP_RATE_100M: return PMP_SPD_100M;
            `PMP_RATE_10M: return PMP_SPD_10M;
            default: return PMP_SPD_1G; // code 11 undefined: fall back to full rate
        endcase
    endfunction
    pmp_pcs_type pcs_d, pcs_q;
    pmp_speed_type speed_d, speed_q;
    logic side_d, side_q;
    // side only matters in serial mode; 1000base-x negotiation has no side
    always_comb begin
        pcs_d = gbe_s ? PMP_PCS_GBE : PMP_PCS_SERIAL; // R5
        side_d = side_s & ~gbe_s; // R4
        speed_d = rate_decode(gbe_s, rate_s);
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pcs_q <= PMP_PCS_SERIAL;
            speed_q <= PMP_SPD_10M;
            side_q <= 1'b0;
        end else begin
            pcs_q <= pcs_d;
            speed_q <= speed_d;
            side_q <= side_d;
        end
    end
    assign pcs_sel_o = pcs_q;
    assign speed_o = speed_q;
    assign an_phy_side_o = side_q;

    ////////////////////////////////////////////////////////////////////////////
    // link timer; short mode trades accuracy for fast simulation of negotiation
    localparam int SHORT_CYC = `PMP_SHORT_CYC;
    logic [31:0] ltmr_d, ltmr_q;
    logic ldone_d, ldone_q;
    always_comb begin
        ldone_d = 1'b0;
        ltmr_d = ltmr_q + 32'h0000_0001;
        if (short_s ? (ltmr_q >= 32'(SHORT_CYC - 1)) : (ltmr_q >= 32'(LINK_CYC - 1))) begin // R8
            ltmr_d = 32'h0000_0000;
            ldone_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ltmr_q <= 32'h0000_0000;
            ldone_q <= 1'b0;
        end else begin
            ltmr_q <= ltmr_d;
            ldone_q <= ldone_d;
        end
    end
    assign link_timer_done_o = ldone_q;

    ////////////////////////////////////////////////////////////////////////////
    // clock-enable sources: pace derived from the rate, looped back outside
    logic [6:0] cediv_d, cediv_q;
    logic ce_d, ce_q;
    logic [1:0] seen_d, seen_q;
    always_comb begin
        cediv_d = cediv_q + 7'h01;
        ce_d = 1'b0;
        unique case (speed_q)
            PMP_SPD_1G: ce_d = 1'b1;
            PMP_SPD_100M: ce_d = (cediv_q[3:0] == 4'h9);
            PMP_SPD_10M: ce_d = (cediv_q == 7'h63);
            default: ce_d = 1'b1;
        endcase
        if (ce_d) begin
            cediv_d = 7'h00;
        end
        seen_d = seen_q | {rx_ce_sink_i, tx_ce_sink_i}; // R9 R10
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cediv_q <= 7'h00;
            ce_q <= 1'b0;
            seen_q <= 2'b00;
        end else begin
            cediv_q <= cediv_d;
            ce_q <= ce_d;
            seen_q <= seen_d;
        end
    end
    assign tx_ce_source_o = ce_q;
    assign rx_ce_source_o = ce_q;
    assign ce_seen_o = seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // management port: writes land in the request cycle, reads delay RD_LAT
    logic mem_we;
    logic [3:0] mem_waddr, mem_raddr;
    logic [15:0] mem_wdata, mem_rdata;
    logic [RD_LAT-1:0] rpipe_d, rpipe_q;
    logic [5:0] roff_d, roff_q;
    logic [15:0] rdat_d, rdat_q;
    logic axi_wr_go, axi_rd_go;
    logic [5:0] axi_woff;
    assign mgmt_ready_o = 1'b1; // R3
    function automatic logic [15:0] mode_word(input logic [4:0] p);
        return {11'h000, p};
    endfunction
    // management writes win the memory write port; the axi write waits until a cycle has no management write
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = mgmt_offset_i[3:0]; // R1
        mem_wdata = mgmt_wdata_i;
        if (mgmt_request_i && mgmt_wr_rdn_i && (mgmt_offset_i[5:4] == 2'b00)) begin // R11 R13
            mem_we = 1'b1;
        end else if (axi_wr_go && (axi_woff[5:4] == 2'b00)) begin
            mem_we = 1'b1;
            mem_waddr = axi_woff[3:0];
            mem_wdata = wd_q[15:0]; // captured word: the master may move wdata once taken
        end
        mem_raddr = mgmt_offset_i[3:0];
        rpipe_d = {rpipe_q[RD_LAT-2:0], mgmt_request_i & ~mgmt_wr_rdn_i}; // R12
        roff_d = (mgmt_request_i && !mgmt_wr_rdn_i) ? mgmt_offset_i : roff_q;
        rdat_d = rdat_q;
        if (rpipe_q[RD_LAT-2]) begin
            if (roff_q == `PMP_OFF_MODE) begin
                rdat_d = mode_word(pin_q);
            end else if (roff_q[5:4] == 2'b00) begin
                rdat_d = mem_rdata; // R2
            end else begin
                rdat_d = 16'h0000;
            end
        end
    end
    pmp_regmem #(.AW(4), .DW(16)) u_mem (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rpipe_q <= '0;
            roff_q <= 6'h00;
            rdat_q <= 16'h0000;
        end else begin
            rpipe_q <= rpipe_d;
            roff_q <= roff_d;
            rdat_q <= rdat_d;
        end
    end
    assign mgmt_rdata_o = rdat_q;
    assign mgmt_rdata_valid_o = rpipe_q[RD_LAT-1]; // R2 R13

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; writes reach management registers, reads show status, mode and last read
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, wblk;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    assign wblk = mgmt_request_i & mgmt_wr_rdn_i;
    assign axi_wr_go = aw_q & w_q & ~bv_q & ~wblk;
    assign axi_woff = awa_q[7:2];
    assign s_axi_awready = ~aw_q & ~bv_q;
    assign s_axi_wready = ~w_q & ~bv_q;
    assign s_axi_arready = ~rv_q;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q & ~s_axi_bready;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (axi_wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = (awa_q < `PMP_AXI_PEND) ? 2'b00 : 2'b10;
        end
        rv_d = rv_q & ~s_axi_rready;
        rd_d = rd_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rresp_d = 2'b00;
            unique case (s_axi_araddr)
                `PMP_AXI_PEND: rd_d = {28'h0000000, ce_q, ldone_q, seen_q};
                `PMP_AXI_RDATA: rd_d = {16'h0000, rdat_q};
                `PMP_AXI_MODE: rd_d = {16'h0000, mode_word(pin_q)};
                default: begin
                    rd_d = 32'h0000_0000;
                    rresp_d = 2'b10;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            bresp_q <= 2'b00;
            rresp_q <= 2'b00;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rresp_q;
endmodule // pmp_mgmt_port

// ==== hdl/pmp_regs.svh ====
// register offsets, field positions, reset values and timing counts of the management port
`ifndef PMP_REGS_SVH
`define PMP_REGS_SVH

// management port word offsets (6-bit offset space)
`define PMP_OFF_CONTROL 6'h00
`define PMP_OFF_STATUS 6'h01
`define PMP_OFF_ADVERT 6'h04
`define PMP_OFF_PARTNER 6'h05
`define PMP_OFF_ANEXP 6'h06
`define PMP_OFF_CFGSRC 6'h0e
`define PMP_OFF_EXTSTAT 6'h0f
`define PMP_OFF_MODE 6'h10

// axi byte addresses: index times four
`define PMP_AXI_MGMT_BASE 8'h00
`define PMP_AXI_PEND 8'h40
`define PMP_AXI_RDATA 8'h44
`define PMP_AXI_MODE 8'h48

// mode status field positions
`define PMP_MODE_SIDE_BIT 0
`define PMP_MODE_GBE_BIT 1
`define PMP_MODE_RATE_LSB 2
`define PMP_MODE_SHORT_BIT 4

// reset values
`define PMP_RST_CONTROL 16'h1140
`define PMP_RST_ADVERT 16'h0001
`define PMP_RST_CFGSRC 16'h0000

// rate codes
`define PMP_RATE_1G 2'b10
`define PMP_RATE_100M 2'b01
`define PMP_RATE_10M 2'b00

// link timer: 1.6 ms normal, 1600 ns short, at 10 MHz (100 ns)
`define PMP_CLK_PERIOD_NS 100
`define PMP_LINK_TIME_NS 1600000
`define PMP_SHORT_TIME_NS 1600
`define PMP_LINK_CYC (`PMP_LINK_TIME_NS / `PMP_CLK_PERIOD_NS)
`define PMP_SHORT_CYC (`PMP_SHORT_TIME_NS / `PMP_CLK_PERIOD_NS)

// read latency of the management port in cycles
`define PMP_RD_LAT 2

`endif

// ==== hdl/pmp_pkg.sv ====
// shared types of the management port block
package pmp_pkg;
    typedef enum logic [1:0] {
        PMP_PCS_SERIAL = 2'b01,
        PMP_PCS_GBE = 2'b10
    } pmp_pcs_type;

    typedef enum logic [2:0] {
        PMP_SPD_10M = 3'b001,
        PMP_SPD_100M = 3'b010,
        PMP_SPD_1G = 3'b100
    } pmp_speed_type;
endpackage

// ==== hdl/pmp_regmem.sv ====
// sixteen-word register memory with registered read data
module pmp_regmem #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    input wire logic core_clk_i, // clock
    input wire logic resetn_i, // async reset, low
    input wire logic we_i, // write strobe
    input wire logic [AW-1:0] waddr_i, // write word
    input wire logic [DW-1:0] wdata_i, // write data
    input wire logic [AW-1:0] raddr_i, // read word
    output logic [DW-1:0] rdata_o // registered read data
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] mem_d [2**AW];
    logic [DW-1:0] rdata_d;

    // next memory image and read word
    always_comb begin
        mem_d = mem_q;
        if (we_i) begin
            mem_d[waddr_i] = wdata_i;
        end
        rdata_d = mem_q[raddr_i];
    end

    // storage; reset clears every word so reads never see unknowns
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rdata_o <= '0;
        end else begin
            mem_q <= mem_d;
            rdata_o <= rdata_d;
        end
    end
endmodule // pmp_regmem

// ==== verif/pmp_chk_monitor.sv ====
// assertion checker for the management port and mode pins
module pmp_chk_monitor #(
    parameter int LINK_CYC = 16000 // normal timer count
) (
    input wire logic core_clk_i, // clock
    input wire logic resetn_i, // reset
    input wire logic mgmt_request_i, // request
    input wire logic mgmt_wr_rdn_i, // direction
    input wire logic mgmt_rdata_valid_o, // read done
    input wire logic mgmt_ready_o, // ready
    input wire logic pcs_gbe_i, // pcs pin
    input wire logic [1:0] rate_sel_i, // rate pins
    input wire logic timer_short_i, // short pin
    input wire logic [1:0] pcs_sel_o, // pcs select
    input wire logic [2:0] speed_o, // speed
    input wire logic link_timer_done_o // timer pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] gap_q, gap_d, run_q, run_d;
    logic short_q;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////
    // gap since last pulse and dwell of the short pin; a period is judged only once settled
    always_comb begin
        gap_d = link_timer_done_o ? 16'h0000 : gap_q + 16'h0001;
        run_d = (timer_short_i != short_q) ? 16'h0000 : run_q + {15'h0000, ~&run_q};
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_q <= 16'h0000;
            run_q <= 16'h0000;
            short_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            run_q <= run_d;
            short_q <= timer_short_i;
        end
    end
    ////////////////////////////////////////////////////////////
    // pins are synchronised, so mode outputs are judged after eight steady cycles
    a_ready_high:
        assert property (mgmt_ready_o) else $error("ready dropped");
    a_read_latency:
        assert property (mgmt_request_i && !mgmt_wr_rdn_i |-> ##2 mgmt_rdata_valid_o)
        else $error("read valid late");
    a_valid_cause:
        assert property (mgmt_rdata_valid_o |-> $past(mgmt_request_i, 2) && !$past(mgmt_wr_rdn_i, 2))
        else $error("read valid without read");
    a_pcs_mode:
        assert property ($stable(pcs_gbe_i) [*8] |-> pcs_sel_o == (pcs_gbe_i ? 2'b10 : 2'b01))
        else $error("pcs select wrong");
    a_gbe_speed:
        assert property ((pcs_gbe_i && $stable(pcs_gbe_i)) [*8] |-> speed_o == 3'b100)
        else $error("gbe speed wrong");
    a_rate_map:
        assert property ((!pcs_gbe_i && $stable(pcs_gbe_i) && $stable(rate_sel_i)) [*8] |->
            speed_o == (rate_sel_i == 2'b00 ? 3'b001 : (rate_sel_i == 2'b01 ? 3'b010 : 3'b100)))
        else $error("rate map wrong");
    a_short_period:
        assert property (link_timer_done_o && timer_short_i && run_q > 16'd40 |-> gap_q == 16'd15)
        else $error("short period wrong");
    a_long_period:
        assert property (link_timer_done_o && !timer_short_i && run_q > 16'(2 * LINK_CYC + 10)
            |-> gap_q == 16'(LINK_CYC - 1))
        else $error("long period wrong");
    c_read: cover property (mgmt_rdata_valid_o);
    c_short: cover property (link_timer_done_o && timer_short_i);
    c_slow: cover property (speed_o == 3'b001);
endmodule // pmp_chk_monitor

// ==== verif/pmp_host_model.sv ====
// host controller model driving the management request port
module pmp_host_model (
    input wire logic clk_i, // clock
    input wire logic [15:0] rdata_i, // read data
    input wire logic rvalid_i, // read done
    output logic req_o, // request
    output logic wr_rdn_o, // direction
    output logic [5:0] offset_o, // offset
    output logic [15:0] wdata_o // write data
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////
    // idle lines carry the inverse of the last value so a late sample shows up
    initial begin
        req_o = 1'b0;
        wr_rdn_o = 1'b0;
        offset_o = 6'h2a;
        wdata_o = 16'h0000;
    end
    // one request cycle with all that qualifies it
    task automatic xfer(input logic wr, input logic [5:0] off, input logic [15:0] d);
        @(posedge clk_i);
        req_o <= 1'b1;
        wr_rdn_o <= wr;
        offset_o <= off;
        wdata_o <= d;
        @(posedge clk_i);
        req_o <= 1'b0;
        wr_rdn_o <= ~wr;
        offset_o <= ~off;
        wdata_o <= ~d;
    endtask
    // read, waiting a bounded time for the strobe
    task automatic rd(input logic [5:0] off, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        d = 16'h0000;
        xfer(1'b0, off, 16'h0000);
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                ok = 1'b1;
            end
        end
    endtask
endmodule // pmp_host_model

// ==== verif/testbench.sv ====
// self-checking bench for the management port block
`include "pmp_regs.svh"
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("Error at %0t: got %h exp %h", $time, got, exp); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LINK_CYC = 40;
    int error_cnt = 0;
    int cmp_count = 0;
    logic clk, resetn, req, wr_rdn, vld, rdy, side, gbe, tshort, an_side, done, tx_ce, rx_ce;
    logic [5:0] off;
    logic [15:0] wd, rd;
    logic [1:0] rate, pcs_sel, seen, bresp, rresp;
    logic [2:0] speed;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    ////////////////////////////////////////////////////////////
    // clock enables are looped straight back, as an integrator must
    pmp_mgmt_port #(.LINK_CYC(LINK_CYC)) i_dut (
        .core_clk_i(clk), .resetn_i(resetn), .mgmt_request_i(req), .mgmt_wr_rdn_i(wr_rdn),
        .mgmt_offset_i(off), .mgmt_wdata_i(wd), .mgmt_rdata_o(rd), .mgmt_rdata_valid_o(vld),
        .mgmt_ready_o(rdy), .side_phy_i(side), .pcs_gbe_i(gbe), .rate_sel_i(rate),
        .timer_short_i(tshort), .an_phy_side_o(an_side), .pcs_sel_o(pcs_sel), .speed_o(speed),
        .link_timer_done_o(done), .tx_ce_sink_i(tx_ce), .tx_ce_source_o(tx_ce),
        .rx_ce_sink_i(rx_ce), .rx_ce_source_o(rx_ce), .ce_seen_o(seen),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    pmp_host_model i_host (
        .clk_i(clk), .rdata_i(rd), .rvalid_i(vld), .req_o(req), .wr_rdn_o(wr_rdn),
        .offset_o(off), .wdata_o(wd)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("TB: %0d errors in %0d compares", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // management read with a bounded wait
    task automatic mrd(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        bit ok;
        i_host.rd(a, d, ok);
        if (!ok) begin
            error_cnt++;
            report_and_stop();
        end
        `CHK(d, e)
    endtask
    // axi write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) {wvalid, wdata} <= {1'b0, ~d};
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            error_cnt++;
            report_and_stop();
        end
        `CHK(bresp, er)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            error_cnt++;
            report_and_stop();
        end
        `CHK(rdata & m, e)
        `CHK(rresp, er)
    endtask
    // every storage word written then read back, plus an unused offset
    task automatic t_regs;
        mrd(6'h05, 16'h0000);
        for (int i = 0; i < 16; i++) i_host.xfer(1'b1, 6'(i), {4'(i), 12'h5a3});
        i_host.xfer(1'b1, 6'h3f, 16'hffff);
        for (int i = 0; i < 16; i++) mrd(6'(i), {4'(i), 12'h5a3});
        mrd(6'h3f, 16'h0000);
    endtask
    // every pcs variant, rate code and side; enables counted over 100 cycles
    task automatic t_modes;
        logic [2:0] sp;
        int n;
        i_host.xfer(1'b1, 6'h10, 16'hffff);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            gbe <= k[2];
            rate <= k[1:0];
            side <= k[0];
            sp = k[2] ? 3'b100 : (k[1:0] == 2'b00 ? 3'b001 : (k[1:0] == 2'b01 ? 3'b010 : 3'b100));
            repeat (10) @(posedge clk);
            `CHK(speed, sp)
            `CHK(pcs_sel, k[2] ? 2'b10 : 2'b01)
            `CHK(an_side, k[0] & ~k[2])
            n = 0;
            repeat (100) begin
                @(posedge clk);
                n += (tx_ce === 1'b1) + (rx_ce === 1'b1);
            end
            `CHK(n, sp[2] ? 200 : (sp[1] ? 20 : 2))
            mrd(6'h10, {11'h000, 1'b0, k[1:0], k[2], k[0]});
        end
        @(posedge clk);
        gbe <= 1'b0;
        rate <= 2'b10;
        side <= 1'b0;
    endtask
    // distance between two timer pulses
    task automatic gap(output int g);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (done !== 1'b1 && g < 200);
        if (n >= 200 || g >= 200) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic t_timer;
        int g;
        @(posedge clk);
        tshort <= 1'b1;
        repeat (60) @(posedge clk);
        gap(g);
        `CHK(g, 16)
        mrd(6'h10, 16'h0018);
        @(posedge clk);
        tshort <= 1'b0;
        repeat (60) @(posedge clk);
        gap(g);
        `CHK(g, LINK_CYC)
    endtask
    // axi window: mirrored write, status, unmapped places
    task automatic t_axi;
        axi_wr(8'h0c, 32'h0000_beef, 2'b00);
        mrd(6'h03, 16'hbeef);
        axi_rd(8'h44, 32'h0000_beef, 32'h0000_ffff, 2'b00);
        axi_rd(8'h40, 32'h0000_0003, 32'h0000_0003, 2'b00);
        axi_rd(8'h50, 32'h0000_0000, 32'hffff_ffff, 2'b10);
        axi_wr(8'h40, 32'h0000_0001, 2'b10);
        axi_rd(8'h48, 32'h0000_0008, 32'hffff_ffff, 2'b00);
        `CHK(seen, 2'b11)
        `CHK(rdy, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        side = 1'b0;
        gbe = 1'b0;
        rate = 2'b10;
        tshort = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        t_timer();
        t_axi();
        report_and_stop();
    end
endmodule // testbench
bind pmp_mgmt_port pmp_chk_monitor #(.LINK_CYC(LINK_CYC)) i_chk (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .mgmt_request_i(mgmt_request_i),
    .mgmt_wr_rdn_i(mgmt_wr_rdn_i), .mgmt_rdata_valid_o(mgmt_rdata_valid_o),
    .mgmt_ready_o(mgmt_ready_o), .pcs_gbe_i(pcs_gbe_i), .rate_sel_i(rate_sel_i),
    .timer_short_i(timer_short_i), .pcs_sel_o(pcs_sel_o), .speed_o(speed_o),
    .link_timer_done_o(link_timer_done_o)
);
